/* rtl/cal_regs_pkg.sv */
/*
 * Constants for the reset, trigger and calibration register group:
 * offsets, fields, reset values, sequence timing.
 * Assumes one 20 MHz clock; registers sit on AXI4-Lite at four times the printed offsets.
 */
package cal_regs_pkg;
    // printed offsets are not all multiples of four: kept as indices
    localparam logic [7:0] IDX_STATUS       = 8'h01;
    localparam logic [7:0] IDX_MODE         = 8'h10;
    localparam logic [7:0] IDX_RATE1        = 8'h11;
    localparam logic [7:0] IDX_RESET        = 8'h24;
    localparam logic [7:0] IDX_INIT2        = 8'h28;
    localparam logic [7:0] IDX_TRIGGER_SAMPLE_COUNT        = 8'h29;
    localparam logic [7:0] IDX_X_OFFSET_VALUE_LO      = 8'h2a;
    localparam logic [7:0] IDX_X_OFFSET_VALUE_HI      = 8'h2b;
    localparam logic [7:0] IDX_Y_OFFSET_VALUE_LO      = 8'h2c;
    localparam logic [7:0] IDX_Y_OFFSET_VALUE_HI      = 8'h2d;
    localparam logic [7:0] IDX_Z_OFFSET_VALUE_LO      = 8'h2e;
    localparam logic [7:0] IDX_Z_OFFSET_VALUE_HI      = 8'h2f;
    localparam logic [7:0] IDX_X_GAIN_LOW        = 8'h30;
    localparam logic [7:0] IDX_Y_GAIN_LOW        = 8'h31;
    localparam logic [7:0] IDX_Z_GAIN_VALUE        = 8'h32;
    localparam int         ADDR_LSB         = 2;
    localparam int         IDX_W            = 8;

    // field positions
    localparam int BIT_RELOAD    = 7;
    localparam int BIT_FORCE_POR = 6;
    localparam int BIT_OTP_BUSY  = 5;
    localparam int BIT_GAIN_MSB  = 7;
    localparam int BIT_SPI_3W    = 0; // own choice inside the mode register
    localparam int SHADOW_LSB    = 4;

    // reset values
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] TRIG_FOREVER = 8'hff;
    localparam logic [2:0] SDR_OFF      = 3'h0;
    localparam logic [7:0] ONE_BYTE     = 8'h01;

    // nonvolatile image: 9 bytes 0x2a..0x32
    localparam int         NV_BYTES = 9;
    localparam logic [3:0] NV_LAST  = 4'h8;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_DONE} seq_state_t;
endpackage

/* rtl/cal_regs.sv */
/*
 * Reset, trigger-count and per-axis offset/gain register group.
 * Assumes an AXI4-Lite master on the same clock, a nonvolatile store that
 * answers one byte per cycle at nv_addr, and a sample path that uses the
 * calibration outputs.
 * Gain bytes are stored and read back; the sample path adds offset only.
 */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
module cal_regs
    import cal_regs_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic [IDX_W+1:0]   s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [IDX_W+1:0]   s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [15:0]        sample_in,
    input  wire logic [1:0]         sample_axis,
    input  wire logic               sample_valid,
    input  wire logic               trigger_start,
    output logic [15:0]             extended_output_regs,
    output logic [1:0]              ext_axis,
    output logic                    ext_valid,
    output logic                    sampling,
    output logic                    spi_four_wire,
    output logic                    otp_enable,
    output logic [3:0]              nv_addr,
    input  wire logic [7:0]         nv_data,
    output logic                    auto_offset_store
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  reset_control_reg;
    logic [7:0]  init_word_two_reg;
    logic [7:0]  trigger_sample_count_reg;
    logic [7:0]  shadow_reg [8];
    logic [7:0]  mode_reg;
    logic [7:0]  rate1_reg;
    logic [7:0]  cal_reg [NV_BYTES];
    seq_state_t  seq_reg;
    logic [3:0]  nv_idx_reg;
    logic        from_por_reg;
    logic [7:0]  samples_left_reg;
    logic        sampling_reg;
    logic [7:0]  mode_seen_reg;

    // write channel latches: address and data may come in either order
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [IDX_W-1:0]  aw_idx_reg;
    logic [31:0]       w_data_reg;
    logic              w_lane0_reg;

    logic              do_write;
    logic [IDX_W-1:0]  ar_idx;
    logic              sdr_mode;
    logic              force_por;
    logic              seq_busy;
    logic [7:0]        rd_byte;
    logic              rd_hit;
    logic              wr_hit;

    // a new write waits until the old response is taken
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign ar_idx   = s_axi_araddr[IDX_W+1:ADDR_LSB];
    assign sdr_mode = rate1_reg[SHADOW_LSB+2:SHADOW_LSB] != SDR_OFF;
    assign force_por = do_write && w_lane0_reg && aw_idx_reg == IDX_RESET
                       && w_data_reg[BIT_FORCE_POR];
    assign seq_busy = seq_reg == SEQ_LOAD;

    ////////////////////////////////////////////////////////////////////////
    // AXI write handshake
    // ready pulses one cycle after valid and drops after the handshake,
    // so a held valid is taken once; the answer waits for both halves
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_idx_reg    <= '0;
            w_data_reg    <= '0;
            w_lane0_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= AXI_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[IDX_W+1:ADDR_LSB];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // decode of writable indices
    // unmapped indices answer with an error and change nothing
    always_comb begin
        wr_hit = 1'b1;
        unique case (aw_idx_reg)
            IDX_MODE, IDX_RATE1, IDX_RESET, IDX_INIT2, IDX_TRIGGER_SAMPLE_COUNT: wr_hit = 1'b1;
            default: wr_hit = aw_idx_reg >= IDX_X_OFFSET_VALUE_LO && aw_idx_reg <= IDX_Z_GAIN_VALUE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control register writes; forced reset returns all to defaults
    // a write during a copy still lands; the copy owns only cal bytes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reset_control_reg        <= RST_BYTE;
            init_word_two_reg        <= RST_BYTE;
            trigger_sample_count_reg <= RST_BYTE;
            mode_reg                 <= RST_BYTE;
            rate1_reg                <= RST_BYTE;
            for (int i = 0; i < 8; i++) shadow_reg[i] <= RST_BYTE;
        end else if (clk_en) begin
            if (force_por) begin
                reset_control_reg        <= RST_BYTE;
                init_word_two_reg        <= RST_BYTE;
                trigger_sample_count_reg <= RST_BYTE;
                mode_reg                 <= RST_BYTE;
                rate1_reg                <= RST_BYTE;
                for (int i = 0; i < 8; i++) shadow_reg[i] <= RST_BYTE;
            end else if (do_write && w_lane0_reg) begin
                unique case (aw_idx_reg)
                    // reserved bits dropped; bit 6 never stored
                    // reload bit stays until host clears it
                    IDX_RESET: reset_control_reg <= {w_data_reg[BIT_RELOAD], 7'h00};
                    IDX_INIT2: init_word_two_reg <= w_data_reg[7:0];
                    IDX_MODE:  mode_reg          <= w_data_reg[7:0];
                    IDX_RATE1: rate1_reg         <= w_data_reg[7:0];
                    IDX_TRIGGER_SAMPLE_COUNT: begin
                        // shadow when rate is software defined
                        if (sdr_mode)
                            shadow_reg[rate1_reg[SHADOW_LSB+2:SHADOW_LSB]] <= w_data_reg[7:0];
                        else
                            trigger_sample_count_reg <= w_data_reg[7:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile copy sequencer, shared by reload and forced reset
    // address k goes out on one edge, byte k comes back on the next,
    // so nine bytes take eleven edges from launch to done
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seq_reg      <= SEQ_IDLE;
            nv_idx_reg   <= '0;
            from_por_reg <= 1'b0;
            otp_enable   <= 1'b0;
            nv_addr      <= '0;
        end else if (clk_en) begin
            unique case (seq_reg)
                SEQ_IDLE: begin
                    // reload starts copy; forced reset too
                    if (force_por || (do_write && w_lane0_reg && aw_idx_reg == IDX_RESET
                                      && w_data_reg[BIT_RELOAD])) begin
                        seq_reg      <= SEQ_LOAD;
                        nv_idx_reg   <= '0;
                        nv_addr      <= '0;
                        from_por_reg <= force_por;
                        otp_enable   <= 1'b1;
                    end
                end
                SEQ_LOAD: begin
                    // nv_data for nv_addr arrives one cycle later
                    nv_addr <= nv_addr + 4'h1;
                    nv_idx_reg <= nv_addr;
                    // core disabled once the last byte is read out
                    // enable drops with the last address, before it runs past
                    // the image; that byte still lands on the next edge
                    if (nv_addr == NV_LAST)
                        otp_enable <= 1'b0;
                    if (nv_idx_reg == NV_LAST)
                        seq_reg <= SEQ_DONE;
                end
                SEQ_DONE: seq_reg <= SEQ_IDLE;
                default:  seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration bytes: loaded from store, overwritten by host
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < NV_BYTES; i++) cal_reg[i] <= RST_BYTE;
            auto_offset_store <= 1'b0;
        end else if (clk_en) begin
            auto_offset_store <= 1'b0;
            if (seq_busy && nv_addr != '0) begin
                cal_reg[nv_addr - 4'h1] <= nv_data;
            end else if (seq_reg == SEQ_DONE && from_por_reg) begin
                // unpack stored auto offset after a forced-reset copy
                auto_offset_store <= 1'b1;
            end else if (do_write && w_lane0_reg && aw_idx_reg >= IDX_X_OFFSET_VALUE_LO
                         && aw_idx_reg <= IDX_Z_GAIN_VALUE) begin
                // gain bytes and gain msb bits land here too
                cal_reg[4'(aw_idx_reg - IDX_X_OFFSET_VALUE_LO)] <= w_data_reg[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial port wiring back to 4-wire on any reset
    // mode bit 0 picks 3-wire; every reset path forces 4-wire back
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            spi_four_wire <= 1'b1;
        end else if (clk_en) begin
            if (force_por)
                spi_four_wire <= 1'b1;
            else if (do_write && w_lane0_reg && aw_idx_reg == IDX_MODE)
                spi_four_wire <= !w_data_reg[BIT_SPI_3W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one-shot sample counting
    // count 0 starts nothing; 1 to 254 counts sample_valid pulses;
    // 255 runs until the mode value changes, so rewriting the same
    // mode does not stop it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            samples_left_reg <= '0;
            sampling_reg     <= 1'b0;
            mode_seen_reg    <= RST_BYTE;
        end else if (clk_en) begin
            mode_seen_reg <= mode_reg;
            if (trigger_start && !sdr_mode && trigger_sample_count_reg != RST_BYTE) begin
                samples_left_reg <= trigger_sample_count_reg;
                sampling_reg     <= 1'b1;
            end else if (sampling_reg && trigger_sample_count_reg == TRIG_FOREVER) begin
                if (mode_seen_reg != mode_reg)
                    sampling_reg <= 1'b0;
            end else if (sampling_reg && sample_valid) begin
                samples_left_reg <= samples_left_reg - ONE_BYTE;
                if (samples_left_reg == ONE_BYTE)
                    sampling_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset added before extended outputs
    // sum wraps at 16 bits, as the output register does
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extended_output_regs <= '0;
            ext_axis             <= '0;
            ext_valid            <= 1'b0;
            sampling             <= 1'b0;
        end else if (clk_en) begin
            sampling  <= sampling_reg;
            ext_valid <= sample_valid;
            if (sample_valid) begin
                ext_axis <= sample_axis;
                // offset bytes: low 7:0, high 6:0 as 14:8, sign extended
                extended_output_regs <= sample_in + {cal_reg[{sample_axis, 1'b1}][6],
                    cal_reg[{sample_axis, 1'b1}][6:0], cal_reg[{sample_axis, 1'b0}]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read side; write-only registers read as zero except calibration
    // reads have no side effects, so a poll loop may hit status freely
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = RST_BYTE;
        unique case (ar_idx)
            IDX_STATUS: begin
                // busy follows the sequencer, not the reload bit
                rd_byte[BIT_OTP_BUSY] = seq_busy;
            end
            IDX_MODE:   rd_byte = mode_reg;
            IDX_RATE1:  rd_byte = rate1_reg;
            IDX_RESET:  rd_byte = reset_control_reg;        // bit 6 reads 0
            IDX_INIT2:  rd_byte = init_word_two_reg;
            IDX_TRIGGER_SAMPLE_COUNT:  rd_byte = RST_BYTE;
            default: begin
                rd_hit = ar_idx >= IDX_X_OFFSET_VALUE_LO && ar_idx <= IDX_Z_GAIN_VALUE;
                if (rd_hit)
                    rd_byte = cal_reg[4'(ar_idx - IDX_X_OFFSET_VALUE_LO)];
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= AXI_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // gain layout: msb in bit 7 of each high offset byte (cal_reg 1, 3, 5),
    // low byte in cal_reg 6..8; no multiply sits here, so a user
    // scaling samples must apply the gain downstream

endmodule // cal_regs

/* verification/cal_regs_chk.sv */
/*
 * Port checker for the reset, trigger and calibration register group.
 * Assumes one clock domain and that clk_en is held high around requests.
 */
`timescale 1ns/1ns
module cal_regs_chk
    import cal_regs_pkg::*;
(
    input logic       clock,
    input logic       rst_n,
    input logic       clk_en,
    input logic       sample_valid,
    input logic [1:0] sample_axis,
    input logic       ext_valid,
    input logic [1:0] ext_axis,
    input logic       sampling,
    input logic       spi_four_wire,
    input logic       otp_enable,
    input logic [3:0] nv_addr,
    input logic       auto_offset_store,
    input logic       s_axi_bvalid,
    input logic       s_axi_bready,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    input logic       s_axi_rready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    // reset state and sample path
    spi_reset_a: assert property ($rose(rst_n) |-> spi_four_wire)
        else $error("serial port not four-wire after reset");
    ext_pulse_a: assert property (sample_valid && clk_en |=> ext_valid)
        else $error("sample did not reach extended output");
    ext_cause_a: assert property (ext_valid && $past(clk_en) |->
        $past(sample_valid) && ext_axis == $past(sample_axis))
        else $error("extended output without matching sample");
    aos_pulse_a: assert property (auto_offset_store && clk_en |=> !auto_offset_store)
        else $error("auto offset unpack longer than one cycle");

    ////////////////////////////////////////////////////////////////
    // store copy: enable held at least eight cycles, then drops within a bound
    otp_span_a: assert property ($rose(otp_enable) |-> otp_enable[*8] ##[1:16] !otp_enable)
        else $error("store enable span wrong");
    nv_range_a: assert property (otp_enable |-> nv_addr <= NV_LAST)
        else $error("store address beyond image");

    ////////////////////////////////////////////////////////////////
    // register bus answers, and freeze while clock enable is low
    r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    freeze_a: assert property (!clk_en |=>
        $stable({ext_valid, sampling, otp_enable, nv_addr, s_axi_rvalid}))
        else $error("state moved while clock enable low");

    cover property ($fell(otp_enable));
    cover property ($fell(sampling));
    cover property ($fell(spi_four_wire));
    cover property (ext_valid);
endmodule // cal_regs_chk

bind cal_regs cal_regs_chk chk (.*);

/* verification/nv_store_model.sv */
/*
 * Nonvolatile calibration store model: a byte one cycle after its address.
 * Assumes the block reads bytes 0 to 8 only while the enable is high.
 */
`timescale 1ns/1ns
module nv_store_model #(
    parameter logic [71:0] IMAGE = 72'h0
) (
    input  logic       clock,
    input  logic       otp_enable,
    input  logic [3:0] nv_addr,
    output logic [7:0] nv_data
);
    logic [7:0] data_reg = 8'h00;

    assign nv_data = data_reg;

    ////////////////////////////////////////////////////////////////
    // factory bytes
    // a disabled store has released its lines: toggle so stale data shows
    always @(posedge clock) begin
        if (otp_enable && nv_addr <= 4'h8) begin
            data_reg <= IMAGE[nv_addr*8 +: 8];
        end else begin
            data_reg <= ~data_reg;
        end
    end
endmodule // nv_store_model

/* verification/cal_regs_bench.sv */
/*
 * Self-checking bench for the reset, trigger and calibration registers.
 * Assumes the store model on the far side and the bound port checker.
 */
`timescale 1ns/1ns
`define chk(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module cal_regs_bench
    import cal_regs_pkg::*;
;
    localparam logic [71:0] IMAGE = 72'h1b2c3d4e5f60718293;
    logic        clock = 1'h0, rst_n = 1'h0, clk_en = 1'h1, trigger_start = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sample_valid = 1'h0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, nv_addr;
    logic [15:0] sample_in = 16'h0000, extended_output_regs;
    logic [1:0]  sample_axis = 2'h0, ext_axis, s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        ext_valid, sampling, spi_four_wire, otp_enable, auto_offset_store;
    logic [7:0]  nv_data, rdv;
    int          failures = 0, compares = 0, aos_seen = 0;

    cal_regs dut (.*);
    nv_store_model #(.IMAGE(IMAGE)) store (.*);

    initial begin
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    // expectations
    function automatic logic [15:0] ext_exp(input logic [15:0] s, input logic [14:0] off);
        return s + {off[14], off};
    endfunction
    function automatic logic [7:0] nvb(input int i);
        return IMAGE[i*8 +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////
    // bus tasks: hold each channel until its own ready
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        fork
            begin
                do @(posedge clock); while (s_axi_awready !== 1'h1);
                s_axi_awvalid <= 1'h0;
            end
            begin
                do @(posedge clock); while (s_axi_wready !== 1'h1);
                s_axi_wvalid <= 1'h0;
            end
        join
        while (s_axi_bvalid !== 1'h1) @(posedge clock);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] idx);
        @(posedge clock);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge clock); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge clock);
        rdv = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        `chk(rdv, exp)
    endtask
    // status poll, bounded; reports whether the first look saw busy
    task automatic wait_idle(output logic first);
        int n = 0;
        rd(IDX_STATUS);
        first = rdv[BIT_OTP_BUSY];
        while (rdv[BIT_OTP_BUSY] !== 1'h0 && n < 50) begin
            rd(IDX_STATUS);
            n++;
        end
    endtask
    // sample and trigger pulses; ext output is read one cycle later
    task automatic smp(input logic [1:0] ax, input logic [15:0] v);
        @(posedge clock);
        sample_in    <= v;
        sample_axis  <= ax;
        sample_valid <= 1'h1;
        @(posedge clock);
        sample_valid <= 1'h0;
        @(posedge clock);
    endtask
    task automatic trig();
        @(posedge clock);
        trigger_start <= 1'h1;
        @(posedge clock);
        trigger_start <= 1'h0;
        repeat (2) @(posedge clock);
    endtask
    task automatic end_sim();
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        if (auto_offset_store === 1'h1) aos_seen++;
    end
    // a hang counts as a mismatch; the run needs about 2300 cycles
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [14:0] off;
        logic [15:0] s;
        logic [7:0]  cnt;
        logic [1:0]  ax;
        logic        b;
        int          n, aos0;
        void'($urandom(32'h7976));
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        `chk(spi_four_wire, 1'h1)
        rdc(IDX_RESET, RST_BYTE);
        `chk(rsp, AXI_OKAY)
        wr(IDX_INIT2, 8'h00);
        `chk(rsp, AXI_OKAY)
        rdc(IDX_INIT2, 8'h00);
        wr(IDX_RESET, 8'h3f);
        rdc(IDX_RESET, 8'h00);
        wr(IDX_TRIGGER_SAMPLE_COUNT, 8'h05);
        rdc(IDX_TRIGGER_SAMPLE_COUNT, 8'h00);
        rd(8'h3f);
        `chk(rsp, AXI_SLVERR)
        wr(8'h3f, 8'h5a);
        `chk(rsp, AXI_SLVERR)
        // a write with lane 0 off stores nothing
        s_axi_wstrb <= 4'he;
        wr(IDX_INIT2, 8'h5a);
        s_axi_wstrb <= 4'hf;
        rdc(IDX_INIT2, 8'h00);
        // reload copies all nine bytes and leaves its bit set
        wr(IDX_RESET, 8'h80);
        wait_idle(b);
        `chk(b, 1'h1)
        rdc(IDX_RESET, 8'h80);
        wr(IDX_RESET, 8'h00);
        for (n = 0; n < NV_BYTES; n++) rdc(IDX_X_OFFSET_VALUE_LO + n[7:0], nvb(n));
        // per-axis offset and gain; first pass uses the most negative offset
        for (n = 0; n < 12; n++) begin
            ax  = 2'(n % 3);
            off = (n < 3) ? 15'h4000 : 15'($urandom());
            b   = 1'($urandom());
            s   = 16'($urandom());
            wr(IDX_X_OFFSET_VALUE_LO + {ax, 1'h0}, off[7:0]);
            wr(IDX_X_OFFSET_VALUE_HI + {ax, 1'h0}, {b, off[14:8]});
            wr(IDX_X_GAIN_LOW + ax, s[15:8]);
            rdc(IDX_X_OFFSET_VALUE_HI + {ax, 1'h0}, {b, off[14:8]});
            rdc(IDX_X_GAIN_LOW + ax, s[15:8]);
            smp(ax, s);
            `chk(ext_valid, 1'h1)
            `chk(extended_output_regs, ext_exp(s, off))
            `chk(ext_axis, ax)
        end
        // a sample during a frozen clock enable is lost
        clk_en <= 1'h0;
        smp(2'h0, 16'h1234);
        `chk(ext_valid, 1'h0)
        clk_en <= 1'h1;
        // trigger counts at both ends; shadow writes must not touch the count
        for (n = 0; n < 3; n++) begin
            cnt = (n == 0) ? 8'h01 : (n == 1) ? 8'hfe : 8'(2 + $urandom_range(4));
            wr(IDX_TRIGGER_SAMPLE_COUNT, cnt);
            wr(IDX_RATE1, 8'h10);
            wr(IDX_TRIGGER_SAMPLE_COUNT, cnt + 8'h03);
            wr(IDX_RATE1, 8'h00);
            trig();
            for (int k = 0; k < cnt; k++) begin
                `chk(sampling, 1'h1)
                smp(2'h1, 16'h0100);
            end
            repeat (2) @(posedge clock);
            `chk(sampling, 1'h0)
        end
        wr(IDX_TRIGGER_SAMPLE_COUNT, TRIG_FOREVER);
        trig();
        repeat (300) smp(2'h2, 16'h0010);
        `chk(sampling, 1'h1)
        wr(IDX_MODE, 8'h02);
        repeat (2) @(posedge clock);
        `chk(sampling, 1'h0)
        // forced reset from three-wire with a dirty offset
        wr(IDX_MODE, 8'h01);
        repeat (2) @(posedge clock);
        `chk(spi_four_wire, 1'h0)
        wr(IDX_X_OFFSET_VALUE_LO, 8'h77);
        aos0 = aos_seen;
        wr(IDX_RESET, 8'h40);
        wait_idle(b);
        `chk(spi_four_wire, 1'h1)
        `chk(aos_seen > aos0, 1'h1)
        rdc(IDX_RESET, 8'h00);
        rdc(IDX_X_OFFSET_VALUE_LO, nvb(0));
        end_sim();
    end
endmodule // cal_regs_bench
